// File: mih_host_if.sv
// Host-side cycle controller for the multiplexed bus
//
// Functional notes
// [R01] One 16-bit shared bus carries all phases
// [R02] Address phase taken on bus clock edge
// [R03] Command phase taken at ALE rise
// [R04] Host samples command strobe at ALE fall; the host model samples the claim line there instead
// [R05] Host strobes command during data phase
// [R06] Host acknowledges requests with command strobe
// [R07] Claim line low while ALE high
// [R08] Request signalled on claim line, ALE low
// [R09] Claim line tri-state, released when idle
// [R10] Ready line extends memory and I/O cycles
// [R11] Ready line runs drive-back cycles
// [R12] Bus reset returns logic to idle
// [R13] Speaker forwarded from slot to host
// [R14] Core supply level latched from ALE
// [R15] Outputs released during reset, until claim
// [R16] All decode runs on bus clock
`timescale 1ns/1ps
`default_nettype none
module mih_host_if
  import mih_pkg::*;
#(
  parameter logic [15:0] WIN_BASE = MIH_WIN_BASE,
  parameter logic [15:0] WIN_MASK = MIH_WIN_MASK,
  parameter int WAIT_CYCLES = MIH_WAIT_CYCLES
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_ALE,
  input wire logic I_CMD_N,
  input wire logic [15:0] I_MUXED_ADDR_DATA_BUS,
  output logic [15:0] O_MUXED_ADDR_DATA_BUS,
  output logic O_MUXED_ADDR_DATA_BUS_OE,
  output logic O_CLAIM_BACKOFF_LINE_N,
  output logic O_CLAIM_BACKOFF_LINE_N_OE,
  output logic O_IOCHRDY,
  output logic O_IOCHRDY_OE,
  input wire logic I_SLOT_SPEAKER,
  output logic O_SPEAKER_OUT_TO_HOST,
  input wire logic I_IRQ_PENDING,
  input wire logic I_DRQ_PENDING,
  input wire logic [15:0] I_READ_DATA,
  output logic [15:0] O_ADDR,
  output logic [15:0] O_CMD_WORD,
  output logic [15:0] O_WRITE_DATA,
  output logic O_WRITE_STB,
  output logic O_CORE_LEVEL
);
  mih_state_t state_q, state_d;
  logic ale_q;
  logic [15:0] addr_q;
  logic [15:0] cmd_q;
  logic [15:0] wdat_q;
  logic wstb_q;
  logic [3:0] wait_q;
  logic rst_seen_q;
  logic core_q;
  logic spk_q;
  logic [15:0] bus_q;
  logic bus_oe_q;
  logic claim_q, claim_oe_q;
  logic rdy_q, rdy_oe_q;
  logic cmd_d_q;

  mih_link_if lnk();

  mih_driveback u_drv (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .lnk(lnk)
  );

  // ALE edges are sampled events in the bus clock domain
  wire ale_rise = I_ALE & ~ale_q; // [R16]
  wire ale_fall = ~I_ALE & ale_q; // [R16]
  // Window match uses the held first phase; the live bus already carries the command at the ALE rise
  wire hit = ((addr_q & WIN_MASK) == (WIN_BASE & WIN_MASK));
  wire any_req = I_IRQ_PENDING | I_DRQ_PENDING;
  wire cmd_now = ~I_CMD_N;
  wire is_write = cmd_q[MIH_IOWR_POS];
  wire wait_done = (wait_q == 4'h0);
  wire [15:0] req_word = {14'h0000, I_DRQ_PENDING, I_IRQ_PENDING};

  // Next state of the cycle controller
  always_comb begin
    state_d = state_q;
    case (state_q)
      MIH_IDLE: begin
        if (ale_rise) begin
          state_d = MIH_PH1;
        end else if (!I_ALE && any_req) begin
          state_d = MIH_REQ;
        end
      end
      MIH_PH1: begin
        if (!I_ALE) begin
          state_d = hit ? MIH_DATA : MIH_IDLE;
        end
      end
      MIH_PH2: state_d = MIH_DATA;
      MIH_DATA: begin
        if (I_CMD_N && cmd_d_q) begin
          state_d = MIH_IDLE;
        end
      end
      MIH_REQ: begin
        if (ale_rise) begin
          state_d = MIH_PH1;
        end else if (cmd_now) begin
          state_d = MIH_DRIVE; // [R06]
        end else if (!any_req) begin
          state_d = MIH_IDLE;
        end
      end
      MIH_DRIVE: begin
        if (!lnk.busy && !lnk.start) begin
          state_d = MIH_IDLE;
        end
      end
      default: state_d = MIH_IDLE;
    endcase
  end

  assign lnk.start = (state_q == MIH_REQ) && cmd_now && !ale_rise;
  assign lnk.req_bits = req_word;

  // ALE history runs through reset too, so a strap level held high at release is no false rise
  always_ff @(posedge I_MCLK) begin
    ale_q <= I_ALE; // [R16]
  end

  // State, command history and strap capture
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state_q <= MIH_IDLE; // [R12]
      cmd_d_q <= 1'b0;
      rst_seen_q <= 1'b1;
      core_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_d_q <= cmd_now;
      rst_seen_q <= 1'b0;
      if (rst_seen_q) begin
        core_q <= I_ALE; // [R14]
      end
    end
  end

  // Phase capture; the address is taken every clock while ALE is low in MIH_IDLE
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      addr_q <= MIH_BUS_RST;
      cmd_q <= MIH_BUS_RST;
    end else begin
      if (!I_ALE && state_q == MIH_IDLE) begin
        addr_q <= I_MUXED_ADDR_DATA_BUS; // [R02]
      end
      if (ale_rise) begin
        cmd_q <= I_MUXED_ADDR_DATA_BUS; // [R03]
      end
    end
  end

  // Write data and wait-state counting in the data phase
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      wdat_q <= MIH_BUS_RST;
      wstb_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      wstb_q <= 1'b0;
      if (state_q == MIH_PH1) begin
        wait_q <= 4'(WAIT_CYCLES);
      end else if (state_q == MIH_DATA && cmd_now && !wait_done) begin
        wait_q <= wait_q - 4'h1;
      end
      if (state_q == MIH_DATA && cmd_now && !cmd_d_q && is_write) begin
        wdat_q <= I_MUXED_ADDR_DATA_BUS; // [R05]
        wstb_q <= 1'b1;
      end
    end
  end

  // Pin drivers; bus, claim and ready released until a cycle is claimed or a request is signalled
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      claim_q <= 1'b1;
      claim_oe_q <= 1'b0; // [R15]
      rdy_q <= 1'b1;
      rdy_oe_q <= 1'b0;
      bus_q <= MIH_BUS_RST;
      bus_oe_q <= 1'b0;
      spk_q <= 1'b0;
    end else begin
      spk_q <= I_SLOT_SPEAKER; // [R13]
      // Claim while ALE high on a hit; request level while ALE low
      claim_oe_q <= (I_ALE && (state_d == MIH_PH1) && hit) // [R07]
                    || (!I_ALE && state_d == MIH_REQ); // [R08] [R09]
      claim_q <= 1'b0;
      // Ready driven while the claimed command is strobed, else from the drive-back sequencer
      if (state_d == MIH_DATA && cmd_now) begin
        rdy_oe_q <= 1'b1; // [R10]
        rdy_q <= wait_done;
      end else if (lnk.rdy_oe) begin
        rdy_oe_q <= 1'b1; // [R11]
        rdy_q <= lnk.rdy_o;
      end else begin
        rdy_oe_q <= 1'b0;
        rdy_q <= 1'b1;
      end
      // Read data only while host strobes a read; host samples it once ready is driven high
      if (state_q == MIH_DATA && cmd_now && !is_write) begin
        bus_oe_q <= 1'b1; // [R01]
        bus_q <= I_READ_DATA;
      end else if (lnk.bus_oe) begin
        bus_oe_q <= 1'b1;
        bus_q <= lnk.bus_o;
      end else begin
        bus_oe_q <= 1'b0; // [R15]
        bus_q <= MIH_BUS_RST;
      end
    end
  end

  assign O_MUXED_ADDR_DATA_BUS = bus_q;
  assign O_MUXED_ADDR_DATA_BUS_OE = bus_oe_q;
  assign O_CLAIM_BACKOFF_LINE_N = claim_q;
  assign O_CLAIM_BACKOFF_LINE_N_OE = claim_oe_q;
  assign O_IOCHRDY = rdy_q;
  assign O_IOCHRDY_OE = rdy_oe_q;
  assign O_SPEAKER_OUT_TO_HOST = spk_q;
  assign O_ADDR = addr_q;
  assign O_CMD_WORD = cmd_q;
  assign O_WRITE_DATA = wdat_q;
  assign O_WRITE_STB = wstb_q;
  assign O_CORE_LEVEL = core_q;
endmodule : mih_host_if
`default_nettype wire

// File: mih_pkg.sv
// Shared constants and types for the multiplexed host bus interface
package mih_pkg;
  localparam int MIH_BUS_W = 16;
  localparam int MIH_PHASE1_LO = 0;
  localparam int MIH_CMD_POS = 15;
  localparam int MIH_IOWR_POS = 14;
  localparam logic [15:0] MIH_BUS_RST = 16'h0000;
  localparam int MIH_WAIT_CYCLES = 2;
  localparam int MIH_DRIVEBACK_CYCLES = 2;
  localparam logic [15:0] MIH_WIN_BASE = 16'h0300;
  localparam logic [15:0] MIH_WIN_MASK = 16'hfff0;

  typedef enum logic [2:0] {
    MIH_IDLE = 3'b000,
    MIH_PH1 = 3'b001,
    MIH_PH2 = 3'b010,
    MIH_DATA = 3'b011,
    MIH_REQ = 3'b100,
    MIH_DRIVE = 3'b101
  } mih_state_t;
endpackage : mih_pkg

// File: mih_link_if.sv
// Bundle between the cycle controller and the drive-back sequencer
`timescale 1ns/1ps
`default_nettype none
interface mih_link_if;
  logic start;
  logic [15:0] req_bits;
  logic busy;
  logic rdy_oe;
  logic rdy_o;
  logic [15:0] bus_o;
  logic bus_oe;
  modport ctl (output start, output req_bits, input busy, input rdy_oe, input rdy_o, input bus_o, input bus_oe);
  modport seq (input start, input req_bits, output busy, output rdy_oe, output rdy_o, output bus_o, output bus_oe);
endinterface : mih_link_if
`default_nettype wire

// File: mih_driveback.sv
// Drive-back sequencer for pending interrupt and DMA requests
`timescale 1ns/1ps
`default_nettype none
module mih_driveback
  import mih_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  mih_link_if.seq lnk
);
  logic [3:0] cnt_q;
  logic [15:0] bits_q;
  logic act_q;

  // Count the drive-back window and strobe the ready output
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
      bits_q <= 16'h0000;
    end else if (!act_q && lnk.start) begin
      act_q <= 1'b1;
      cnt_q <= 4'(MIH_DRIVEBACK_CYCLES);
      bits_q <= lnk.req_bits;
    end else if (act_q) begin
      if (cnt_q == 4'h1) begin
        act_q <= 1'b0;
      end
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign lnk.busy = act_q;
  assign lnk.rdy_oe = act_q; // [R11]
  assign lnk.rdy_o = act_q & (cnt_q == 4'(MIH_DRIVEBACK_CYCLES)); // [R11]
  assign lnk.bus_oe = act_q; // [R01]
  assign lnk.bus_o = bits_q;
endmodule : mih_driveback
`default_nettype wire

// File: mih_host_if_props.sv
// Port checker for the host interface
`timescale 1ns/1ps
`default_nettype none
module mih_host_if_props
  import mih_pkg::*;
#(
  parameter logic [15:0] WIN_BASE = MIH_WIN_BASE,
  parameter logic [15:0] WIN_MASK = MIH_WIN_MASK
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_ALE,
  input wire logic I_CMD_N,
  input wire logic [15:0] I_MUXED_ADDR_DATA_BUS,
  input wire logic I_SLOT_SPEAKER,
  input wire logic O_MUXED_ADDR_DATA_BUS_OE,
  input wire logic O_CLAIM_BACKOFF_LINE_N_OE,
  input wire logic O_IOCHRDY,
  input wire logic O_IOCHRDY_OE,
  input wire logic O_SPEAKER_OUT_TO_HOST,
  input wire logic [15:0] O_ADDR,
  input wire logic [15:0] O_CMD_WORD,
  input wire logic O_CORE_LEVEL
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  // Window hit uses the address held before the latch strobe rises
  wire logic hit = (O_ADDR & WIN_MASK) == WIN_BASE;
  chk_reset_quiet: assert property (disable iff (1'b0) I_RESET |=>
    !O_CLAIM_BACKOFF_LINE_N_OE && !O_IOCHRDY_OE && !O_MUXED_ADDR_DATA_BUS_OE) else $error("driven in reset");
  chk_speaker_copy: assert property (1 |=> O_SPEAKER_OUT_TO_HOST == $past(I_SLOT_SPEAKER)) else $error("speaker");
  chk_core_strap: assert property ($fell(I_RESET) |=> O_CORE_LEVEL == $past(I_ALE)) else $error("strap");
  chk_claim_window: assert property ($rose(I_ALE) && hit |=> O_CLAIM_BACKOFF_LINE_N_OE) else $error("no claim");
  chk_refuse_claim: assert property ($rose(I_ALE) && !hit |=> !O_CLAIM_BACKOFF_LINE_N_OE) else $error("claim");
  chk_cmd_capture: assert property ($rose(I_ALE) |=> O_CMD_WORD == $past(I_MUXED_ADDR_DATA_BUS)) else $error("cmd");
  chk_ready_in_cmd: assert property (O_IOCHRDY_OE |-> !$past(I_CMD_N)) else $error("ready");
  chk_bus_in_cmd: assert property (O_MUXED_ADDR_DATA_BUS_OE |-> !$past(I_CMD_N)) else $error("bus");
  cover property ($rose(O_CLAIM_BACKOFF_LINE_N_OE));
  cover property (O_IOCHRDY_OE && O_IOCHRDY);
  cover property (O_MUXED_ADDR_DATA_BUS_OE);
endmodule : mih_host_if_props
`default_nettype wire

// File: mih_host_model.sv
// Host chipset model that masters the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module mih_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_bus,
  input wire logic i_bus_oe,
  input wire logic i_claim_oe,
  input wire logic i_rdy,
  input wire logic i_rdy_oe,
  output var logic o_ale,
  output var logic o_cmd_n,
  output logic [15:0] o_bus
);
  logic drv = 1'b0;
  logic [15:0] val = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  initial o_ale = 1'b0;
  initial o_cmd_n = 1'b1;
  // Released wire toggles so a stale value can never pass
  assign o_bus = i_bus_oe ? i_bus : drv ? val : ~last_q;
  always @(posedge i_clk) last_q <= o_bus;
  // One memory or I/O cycle; n counts ready-low cycles, 8 means none came
  task automatic cyc(input logic [15:0] a, c, wd, output logic [15:0] rd, output logic cl, output int n);
    @(negedge i_clk);
    val = a;
    drv = 1'b1;
    @(negedge i_clk);
    o_ale = 1'b1;
    val = c;
    repeat (2) @(negedge i_clk);
    cl = i_claim_oe;
    o_ale = 1'b0;
    val = wd;
    drv = c[14];
    @(negedge i_clk);
    o_cmd_n = 1'b0;
    n = 0;
    @(negedge i_clk);
    while (!(i_rdy_oe && i_rdy) && n < 8) begin
      n++;
      @(negedge i_clk);
    end
    rd = o_bus;
    o_cmd_n = 1'b1;
    drv = 1'b0;
    @(negedge i_clk);
  endtask : cyc
  // Acknowledge a pending request and take the drive-back word
  task automatic ack(output logic [15:0] w);
    int n;
    n = 0;
    o_cmd_n = 1'b0;
    while (!(i_rdy_oe && i_rdy) && n < 8) begin
      n++;
      @(negedge i_clk);
    end
    w = o_bus;
    // Let go one clock after the word; a longer hold acknowledges a still-pending request again
    @(negedge i_clk);
    o_cmd_n = 1'b1;
  endtask : ack
endmodule : mih_host_model
`default_nettype wire

// File: mih_host_if_tb.sv
// Self-checking bench for the host interface
`timescale 1ns/1ps
`default_nettype none
module mih_host_if_tb import mih_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spk = 1'b0;
  logic irq = 1'b0;
  logic drq = 1'b0;
  logic [15:0] rdata = 16'h0000;
  wire logic ale, cmd_n, bus_oe, cl_n, cl_oe, rdy, rdy_oe, wstb, core, spk_o;
  wire logic [15:0] bus_in, bus_o, addr, cmdw, wdat;
  int bad_count = 0;
  int cmp_count = 0;
  int stb_count = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (wstb) stb_count++;
  mih_host_if dut (.I_MCLK(clk), .I_RESET(rst), .I_ALE(ale), .I_CMD_N(cmd_n), .I_MUXED_ADDR_DATA_BUS(bus_in),
    .O_MUXED_ADDR_DATA_BUS(bus_o), .O_MUXED_ADDR_DATA_BUS_OE(bus_oe), .O_CLAIM_BACKOFF_LINE_N(cl_n),
    .O_CLAIM_BACKOFF_LINE_N_OE(cl_oe), .O_IOCHRDY(rdy), .O_IOCHRDY_OE(rdy_oe), .I_SLOT_SPEAKER(spk),
    .O_SPEAKER_OUT_TO_HOST(spk_o), .I_IRQ_PENDING(irq), .I_DRQ_PENDING(drq), .I_READ_DATA(rdata), .O_ADDR(addr),
    .O_CMD_WORD(cmdw), .O_WRITE_DATA(wdat), .O_WRITE_STB(wstb), .O_CORE_LEVEL(core));
  mih_host_model host (.i_clk(clk), .i_bus(bus_o), .i_bus_oe(bus_oe), .i_claim_oe(cl_oe), .i_rdy(rdy),
    .i_rdy_oe(rdy_oe), .o_ale(ale), .o_cmd_n(cmd_n), .o_bus(bus_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Latch strobe held high across release to set the core level
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    host.o_ale = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'({bus_oe, cl_oe, rdy_oe}), 16'h0000);
    rst = 1'b0;
    @(negedge clk);
    host.o_ale = 1'b0;
    @(negedge clk);
    chk(16'(core), 16'h0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cycles;
    logic [15:0] rd;
    logic cl;
    int n;
    host.cyc(16'h0305, 16'h4000, 16'ha55a, rd, cl, n);
    chk(addr, 16'h0305);
    chk(16'(cl), 16'h0001);
    chk(cmdw, 16'h4000);
    chk(wdat, 16'ha55a);
    chk(16'(stb_count), 16'h0001);
    chk(16'(n), 16'(MIH_WAIT_CYCLES));
    rdata = 16'h1234;
    host.cyc(16'h030f, 16'h0000, 16'h0000, rd, cl, n);
    chk(rd, 16'h1234);
    // Addresses just outside both edges of the window are refused with no ready
    host.cyc(16'h02ff, 16'h0000, 16'h0000, rd, cl, n);
    chk(16'({cl, 8'(n)}), 16'h0008);
    host.cyc(16'h0310, 16'h4000, 16'h0000, rd, cl, n);
    chk(16'({cl, 8'(n)}), 16'h0008);
    $display("test cycles done");
  endtask : t_cycles
  task automatic t_req;
    logic [15:0] w;
    for (int k = 1; k < 4; k++) begin
      @(negedge clk);
      irq = k[0];
      drq = k[1];
      repeat (2) @(negedge clk);
      chk(16'({cl_oe, cl_n}), 16'h0002);
      host.ack(w);
      irq = 1'b0;
      drq = 1'b0;
      chk(16'(w[1:0]), 16'(k));
      repeat (2) @(negedge clk);
      chk(16'(cl_oe), 16'h0000);
    end
    $display("test requests done");
  endtask : t_req
  task automatic t_spk;
    for (int v = 1; v >= 0; v--) begin
      @(negedge clk);
      spk = v[0];
      @(negedge clk);
      chk(16'(spk_o), 16'(v));
    end
    $display("test speaker done");
  endtask : t_spk
  initial begin
    t_reset();
    t_cycles();
    t_req();
    t_reset();
    t_spk();
    close_out();
  end
  // About 90 cycles of work; cut off well beyond that
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule : mih_host_if_tb
bind mih_host_if mih_host_if_props #(.WIN_BASE(WIN_BASE), .WIN_MASK(WIN_MASK)) u_props (.I_MCLK(I_MCLK),
  .I_RESET(I_RESET), .I_ALE(I_ALE), .I_CMD_N(I_CMD_N), .I_MUXED_ADDR_DATA_BUS(I_MUXED_ADDR_DATA_BUS),
  .I_SLOT_SPEAKER(I_SLOT_SPEAKER), .O_MUXED_ADDR_DATA_BUS_OE(O_MUXED_ADDR_DATA_BUS_OE),
  .O_CLAIM_BACKOFF_LINE_N_OE(O_CLAIM_BACKOFF_LINE_N_OE), .O_IOCHRDY(O_IOCHRDY), .O_IOCHRDY_OE(O_IOCHRDY_OE),
  .O_SPEAKER_OUT_TO_HOST(O_SPEAKER_OUT_TO_HOST), .O_ADDR(O_ADDR), .O_CMD_WORD(O_CMD_WORD),
  .O_CORE_LEVEL(O_CORE_LEVEL));
`default_nettype wire
